// ### reset_cause_cfg.svh
// Purpose: Constants for the reset-cause and reset-source control block
// Assumes: APB with 32-bit data, word-aligned registers, 100 MHz pclk
// Notes:   Register indices are word indices; byte address is index * 4
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

// Register word indices (byte address = index * 4)
`define CAUSE_IDX      10'h0ef
`define IRQ_STAT_IDX   10'h0f0
`define IRQ_MASK_IDX   10'h0f1

// Reset-cause register bit positions
`define BIT_USB        7
`define BIT_MEM        6
`define BIT_CMP        5
`define BIT_SW         4
`define BIT_WDT        3
`define BIT_MCD        2
`define BIT_POR        1
`define BIT_PIN        0

// Reset values
`define CAUSE_RST      8'h02
`define IRQ_RST        4'h0

// Interrupt status bit positions (source tripped while not enabled)
`define IRQ_CMP        0
`define IRQ_VDD        1
`define IRQ_MCD        2
`define IRQ_USB        3

// System reset pulse length
`define CLK_PERIOD_NS  10
`define RESET_HOLD_NS  100
`define RESET_HOLD_CYC 4'((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### reset_cause_pkg.sv
// Purpose: Types for the reset-cause and reset-source control block
// Assumes: Constants live in reset_cause_cfg.svh
// Notes:   Sequencer has two states only
package reset_cause_pkg;

	// Reset sequencer state
	typedef enum logic [0:0] {
		ST_RUN  = 1'b0,
		ST_HOLD = 1'b1
	} seq_state_t;

endpackage

// ### reset_source_control.sv
// Purpose: Reset-source enables, software reset, cause flags, APB access
// Assumes: All inputs synchronous to pclk; presetn is the power-on reset
// Notes:   Cause flags and enables survive the system resets they record
`include "reset_cause_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Bit 7 write enables usb reset; reads 1 if usb caused last reset.
// - Bit 6 read-only; 1 if program store access error caused reset.
// - Bit 5 write enables comparator reset, active low; reads comparator cause.
// - Writing 1 to bit 4 forces reset at once; then reads 1.
// - Bit 3 read-only; 1 if watchdog overflow caused last reset.
// - Bit 2 write enables missing-clock detector; reads detector-caused reset.
// - Bit 1 write enables supply monitor reset; software waits for stability.
// - Bit 1 reads 1 after power-on or supply reset; others then read 0.
// - Bit 0 read-only; 1 if external reset pin caused last reset.
// - Writing 0 disables detector; bit reads 0 after non-detector resets.
// - Internal resets never drive the external reset pin.
// - Usb enabled: reset on bus reset or matching bus-power edge.
module reset_source_control (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_reset_n,
	input  wire logic        watchdog_overflow,
	input  wire logic        program_store_error,
	input  wire logic        comparator_out,
	input  wire logic        supply_ok,
	input  wire logic        clock_missing,
	input  wire logic        usb_bus_reset,
	input  wire logic        bus_power_level,
	input  wire logic        bus_power_edge_polarity,
	output logic             missing_clock_detector_en,
	output logic             sys_reset_n,
	output logic             irq
);

	// Register state
	logic [7:0]                     cause_ff;
	logic                           usb_en_ff;
	logic                           cmp_en_ff;
	logic                           mcd_en_ff;
	logic                           vdd_en_ff;
	logic [3:0]                     irq_stat_ff;
	logic [3:0]                     irq_mask_ff;
	logic                           irq_ff;
	logic [31:0]                    prdata_ff;
	logic                           pready_ff;
	logic                           pslverr_ff;
	logic                           bus_power_prev_ff;
	logic [3:0]                     hold_cnt_ff;
	logic                           sys_reset_n_ff;
	logic                           edge_armed_ff;
	logic                           det_en_ff;
	reset_cause_pkg::seq_state_t    state_ff;
	reset_cause_pkg::seq_state_t    nxt_state;
	logic [3:0]                     nxt_hold_cnt;
	logic [7:0]                     nxt_cause;
	logic [3:0]                     nxt_irq_stat;
	logic [31:0]                    nxt_prdata;

	// Decoded bus and source terms
	logic                           sel_cause;
	logic                           sel_stat;
	logic                           sel_mask;
	logic                           sel_any;
	logic                           apb_done;
	logic                           apb_wr;
	logic                           sw_trip;
	logic                           bus_power_edge;
	logic                           usb_event;
	logic                           cmp_trip;
	logic                           vdd_trip;
	logic                           mcd_trip;
	logic                           usb_trip;
	logic                           pin_trip;
	logic                           cause_hit;
	logic                           running;
	logic [3:0]                     blocked;

	// Address decode on word index; low address bits must be zero
	assign sel_cause = (paddr[11:2] == `CAUSE_IDX) && (paddr[1:0] == 2'h0);
	assign sel_stat  = (paddr[11:2] == `IRQ_STAT_IDX) && (paddr[1:0] == 2'h0);
	assign sel_mask  = (paddr[11:2] == `IRQ_MASK_IDX) && (paddr[1:0] == 2'h0);
	assign sel_any   = sel_cause | sel_stat | sel_mask;

	// Transfer completes at the edge that samples pready high
	assign apb_done = psel & penable & pready_ff;
	assign apb_wr   = apb_done & pwrite & sel_any;

	// Software force; only acts while the system is running
	assign running = (state_ff == reset_cause_pkg::ST_RUN);
	assign sw_trip = apb_wr & sel_cause & pwdata[`BIT_SW];

	// Bus-power edge matching the selected polarity; none until armed
	always_comb begin
		if (!edge_armed_ff) begin
			bus_power_edge = 1'b0;
		end else if (bus_power_edge_polarity) begin
			bus_power_edge = bus_power_level & ~bus_power_prev_ff;
		end else begin
			bus_power_edge = ~bus_power_level & bus_power_prev_ff;
		end
	end
	assign usb_event = usb_bus_reset | bus_power_edge;

	// Enabled reset sources
	assign pin_trip = ~ext_reset_n;
	assign usb_trip = usb_event & usb_en_ff;
	assign cmp_trip = ~comparator_out & cmp_en_ff;
	assign vdd_trip = ~supply_ok & vdd_en_ff;
	assign mcd_trip = clock_missing & mcd_en_ff;

	// Source events that occur while their enable is off
	assign blocked[`IRQ_CMP] = ~comparator_out & ~cmp_en_ff;
	assign blocked[`IRQ_VDD] = ~supply_ok & ~vdd_en_ff;
	assign blocked[`IRQ_MCD] = clock_missing & ~mcd_en_ff;
	assign blocked[`IRQ_USB] = usb_event & ~usb_en_ff;

	// Pick one cause; pin and supply first, software last
	// A held pin always wins, so a pressed button is what gets reported
	always_comb begin
		nxt_cause = 8'h00;
		cause_hit = 1'b1;
		if (pin_trip) begin
			nxt_cause[`BIT_PIN] = 1'b1;
		end else if (vdd_trip) begin
			nxt_cause[`BIT_POR] = 1'b1;
		end else if (program_store_error) begin
			nxt_cause[`BIT_MEM] = 1'b1;
		end else if (watchdog_overflow) begin
			nxt_cause[`BIT_WDT] = 1'b1;
		end else if (mcd_trip) begin
			nxt_cause[`BIT_MCD] = 1'b1;
		end else if (cmp_trip) begin
			nxt_cause[`BIT_CMP] = 1'b1;
		end else if (usb_trip) begin
			nxt_cause[`BIT_USB] = 1'b1;
		end else if (sw_trip) begin
			nxt_cause[`BIT_SW] = 1'b1;
		end else begin
			cause_hit = 1'b0;
		end
	end

	// Sequencer: enter hold on a cause, stay while the pin is low
	// A level still active when the hold ends trips again at once
	always_comb begin
		nxt_state    = state_ff;
		nxt_hold_cnt = hold_cnt_ff;
		unique case (state_ff)
			reset_cause_pkg::ST_RUN: begin
				if (cause_hit) begin
					nxt_state    = reset_cause_pkg::ST_HOLD;
					nxt_hold_cnt = `RESET_HOLD_CYC;
				end
			end
			reset_cause_pkg::ST_HOLD: begin
				if (pin_trip) begin
					nxt_hold_cnt = `RESET_HOLD_CYC;
				end else if (hold_cnt_ff > 4'h1) begin
					nxt_hold_cnt = hold_cnt_ff - 4'h1;
				end else begin
					nxt_hold_cnt = 4'h0;
					nxt_state    = reset_cause_pkg::ST_RUN;
				end
			end
		endcase
	end

	// Sequencer state and hold counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= reset_cause_pkg::ST_RUN;
			hold_cnt_ff <= 4'h0;
		end else begin
			state_ff    <= nxt_state;
			hold_cnt_ff <= nxt_hold_cnt;
		end
	end

	// System reset output; the external pin is input only
	// Registered so decode glitches never reach the reset net
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset_n_ff <= 1'b0;
		end else begin
			sys_reset_n_ff <= (nxt_state == reset_cause_pkg::ST_RUN);
		end
	end

	// Cause flags: power-on value marks the supply flag
	// Trips seen during the hold are not recorded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_ff <= `CAUSE_RST;
		end else if (running && cause_hit) begin
			cause_ff <= nxt_cause;
		end
	end

	// Source enables, written from whole register values
	// Read-only positions are never stored; presetn or a write of 0 clears an enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_en_ff <= 1'b0;
			cmp_en_ff <= 1'b0;
			mcd_en_ff <= 1'b0;
			vdd_en_ff <= 1'b0;
		end else if (apb_wr && sel_cause) begin
			usb_en_ff <= pwdata[`BIT_USB];
			cmp_en_ff <= pwdata[`BIT_CMP];
			mcd_en_ff <= pwdata[`BIT_MCD];
			vdd_en_ff <= pwdata[`BIT_POR];
		end
	end

	// Detector enable copy; one cycle behind the stored enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_en_ff <= 1'b0;
		end else begin
			det_en_ff <= mcd_en_ff;
		end
	end

	// Previous bus-power level for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_power_prev_ff <= 1'b0;
		end else begin
			bus_power_prev_ff <= bus_power_level;
		end
	end

	// Edge detector armed one cycle after power-on, so a bus
	// already powered at release does not look like a fresh edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_armed_ff <= 1'b0;
		end else begin
			edge_armed_ff <= 1'b1;
		end
	end

	// Sticky status: set wins over write-one-to-clear
	// An event in the clearing cycle is never lost
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (apb_wr && sel_stat) begin
			nxt_irq_stat = irq_stat_ff & ~pwdata[3:0];
		end
		nxt_irq_stat = nxt_irq_stat | blocked;
	end

	// Interrupt status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= `IRQ_RST;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// Interrupt mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= `IRQ_RST;
		end else if (apb_wr && sel_mask) begin
			irq_mask_ff <= pwdata[3:0];
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	// Read data mux; writes to read-only cause bits are dropped
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (sel_cause) begin
			nxt_prdata[7:0] = cause_ff;
		end else if (sel_stat) begin
			nxt_prdata[3:0] = irq_stat_ff;
		end else if (sel_mask) begin
			nxt_prdata[3:0] = irq_mask_ff;
		end
	end

	// One wait state: pready rises in the second access cycle
	// Writes act only at the edge that sees it high, never earlier
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= ~sel_any;
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Read data stands only beside pready; zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && penable && !pready_ff) begin
			prdata_ff <= nxt_prdata;
		end else begin
			prdata_ff <= 32'h0000_0000;
		end
	end

	// Output wiring
	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign sys_reset_n = sys_reset_n_ff;
	assign irq         = irq_ff;
	assign missing_clock_detector_en = det_en_ff;

endmodule
`default_nettype wire

// ### reset_source_control_sva.sv
// Purpose: Port checker for reset_source_control
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound to every instance below
`timescale 1ns/1ns
`default_nettype none
module reset_source_control_sva (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	ext_reset_n,
	input wire logic	watchdog_overflow,
	input wire logic	program_store_error,
	input wire logic	missing_clock_detector_en,
	input wire logic	sys_reset_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Setup then access, and a committed cause write
	sequence s_xfer;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_cause_wr;
		pready && pwrite && paddr == 12'h3bc;
	endsequence
	chk_one_wait: assert property (s_xfer |=> pready) else $error("late");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("held");
	chk_unmapped_err: assert property (pready |->
		pslverr == !(paddr inside {12'h3bc, 12'h3c0, 12'h3c4})) else $error("pslverr");
	chk_sw_force: assert property (s_cause_wr ##0 (pwdata[4] && sys_reset_n)
		|=> !sys_reset_n) else $error("no sw reset");
	chk_pin_trip: assert property (!ext_reset_n && sys_reset_n |=> !sys_reset_n)
		else $error("no pin reset");
	chk_fault_trip: assert property ((watchdog_overflow || program_store_error)
		&& sys_reset_n |=> !sys_reset_n) else $error("no fault reset");
	chk_hold_len: assert property ($fell(sys_reset_n) |->
		!sys_reset_n [*8] ##1 !sys_reset_n ##1 !sys_reset_n
		##[1:40] sys_reset_n) else $error("hold");
	chk_detector_en: assert property (s_cause_wr |=> ##1
		missing_clock_detector_en == $past(pwdata[2], 2)) else $error("detector");
endmodule
bind reset_source_control reset_source_control_sva u_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .ext_reset_n, .watchdog_overflow,
	.program_store_error, .missing_clock_detector_en, .sys_reset_n);
`default_nettype wire

// ### reset_partner.sv
// Purpose: Model of the reset pin and internal reset sources
// Assumes: Bench requests a one-hot trip vector
// Notes:   Each trip lasts one cycle; lines idle inactive
`timescale 1ns/1ns
`default_nettype none
module reset_partner (
	input wire logic	pclk,
	input wire logic [7:0]	pulse,
	output logic	ext_reset_n,
	output logic	supply_ok,
	output logic	clock_missing,
	output logic	watchdog_overflow,
	output logic	bus_power_level,
	output logic	comparator_out,
	output logic	program_store_error,
	output logic	usb_bus_reset
);
	logic [7:0]	act_ff = '0;
	// Registered trip, indexed like the cause flags except bit 4, which drives bus power
	always_ff @(posedge pclk) begin
		act_ff <= pulse;
	end
	// Active-low lines idle high
	assign ext_reset_n = !act_ff[0];
	assign supply_ok = !act_ff[1];
	assign clock_missing = act_ff[2];
	assign watchdog_overflow = act_ff[3];
	assign bus_power_level = act_ff[4];
	assign comparator_out = !act_ff[5];
	assign program_store_error = act_ff[6];
	assign usb_bus_reset = act_ff[7];
endmodule
`default_nettype wire

// ### reset_source_control_tb.sv
// Purpose: Self-checking bench for reset_source_control
// Assumes: reset_partner plays every reset source
// Notes:   LFSR bits land in the read-only places
`timescale 1ns/1ns
`default_nettype none
module reset_source_control_tb;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [11:0]	paddr = '0;
	logic [31:0]	pwdata = '0;
	logic [31:0]	prdata;
	logic		pready, pslverr, irq, det_en, sys_reset_n;
	wire logic [7:0]	srcs;
	logic		bus_power_edge_polarity = 1'b1;
	logic [7:0]	pulse = '0;
	logic [31:0]	seed = 32'h0001_428b;
	logic [31:0]	rd_data;
	logic		rd_err;
	int		mismatches = 0;
	int		n_compared = 0;
	int		cyc = 0;
	reset_source_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_reset_n(srcs[0]), .supply_ok(srcs[1]),
		.clock_missing(srcs[2]), .watchdog_overflow(srcs[3]), .bus_power_level(srcs[4]),
		.comparator_out(srcs[5]), .program_store_error(srcs[6]), .usb_bus_reset(srcs[7]),
		.bus_power_edge_polarity, .missing_clock_detector_en(det_en), .sys_reset_n,
		.irq);
	reset_partner u_partner (.pclk, .pulse, .ext_reset_n(srcs[0]), .supply_ok(srcs[1]),
		.clock_missing(srcs[2]), .watchdog_overflow(srcs[3]), .bus_power_level(srcs[4]),
		.comparator_out(srcs[5]), .program_store_error(srcs[6]), .usb_bus_reset(srcs[7]));
	// Clock and hang guard
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Bus-power edge reports as the usb flag
	function automatic logic [31:0] exp_cause(input int k);
		return (k == 4) ? 32'h0000_0080 : 32'h0000_0001 << k;
	endfunction
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, '0);
		check(nm, rd_data, x);
	endtask
	task automatic trip(input int k);
		@(posedge pclk);
		pulse <= 8'h01 << k;
		@(posedge pclk);
		pulse <= '0;
	endtask
	task automatic wait_rst();
		do @(posedge pclk); while (sys_reset_n !== 1'b0);
		do @(posedge pclk); while (sys_reset_n !== 1'b1);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd("cause", 12'h3bc, 32'h0000_0002);
		apb(1'b0, 12'h3b8, '0);
		check("unmapped", 32'(rd_err), 32'h0000_0001);
		apb(1'b0, 12'h3bd, '0);
		check("misaligned", 32'(rd_err), 32'h0000_0001);
		$display("reset values done");
		seed = lfsr(seed);
		apb(1'b1, 12'h3bc, (seed & 32'h0000_0049) | 32'h0000_00a6);
		for (int k = 0; k < 8; k++) begin
			trip(k);
			wait_rst();
			rd("cause", 12'h3bc, exp_cause(k));
		end
		check("detector", 32'(det_en), 32'h0000_0001);
		$display("source loop done");
		apb(1'b1, 12'h3bc, 32'h0000_0010);
		wait_rst();
		rd("cause", 12'h3bc, 32'h0000_0010);
		check("detector", 32'(det_en), '0);
		$display("software reset done");
		bus_power_edge_polarity <= 1'b0;
		apb(1'b1, 12'h3bc, 32'h0000_0080);
		trip(4);
		repeat (2) @(posedge pclk);
		check("rise ignored", 32'(sys_reset_n), 32'h0000_0001);
		wait_rst();
		rd("cause", 12'h3bc, 32'h0000_0080);
		$display("falling polarity done");
		// Disabled sources only raise status
		apb(1'b1, 12'h3c4, 32'h0000_0001);
		trip(5);
		trip(2);
		repeat (6) @(posedge pclk);
		check("irq", 32'(irq), 32'h0000_0001);
		check("running", 32'(sys_reset_n), 32'h0000_0001);
		rd("status", 12'h3c0, 32'h0000_0005);
		apb(1'b1, 12'h3c0, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check("irq", 32'(irq), '0);
		rd("cause", 12'h3bc, 32'h0000_0080);
		$display("interrupt done");
		apb(1'b1, 12'h3bc, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		check("detector", 32'(det_en), 32'h0000_0001);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		check("detector", 32'(det_en), '0);
		rd("cause", 12'h3bc, 32'h0000_0002);
		$display("power-on reset done");
		complete_run();
	end
endmodule
`default_nettype wire
